// ===== logic/sync_pulse_output_config.sv
// Purpose: register bank and drivers for the frame and multiframe sync outputs
// Assumes: AXI4-Lite slave, all inputs but sys_rst synchronous to ref_clk at 125 MHz
// Notes:   registers are 8 bits in the low byte of an aligned word
`default_nettype none
`include "sync_pulse_defs.svh"
module sync_pulse_output_config (
  input  wire logic        ref_clk,                  // system clock
  input  wire logic        sys_rst,                  // async reset, high
  input  wire logic [11:0] awaddr,                   // write address
  input  wire logic [2:0]  awprot,                   // unused
  input  wire logic        awvalid,                  // write address valid
  output logic             awready,                  // write address ready
  input  wire logic [31:0] wdata,                    // write data
  input  wire logic [3:0]  wstrb,                    // byte strobes
  input  wire logic        wvalid,                   // write data valid
  output logic             wready,                   // write data ready
  output logic [1:0]       bresp,                    // write answer
  output logic             bvalid,                   // write answer valid
  input  wire logic        bready,                   // write answer taken
  input  wire logic [11:0] araddr,                   // read address
  input  wire logic [2:0]  arprot,                   // unused
  input  wire logic        arvalid,                  // read address valid
  output logic             arready,                  // read address ready
  output logic [31:0]      rdata,                    // read data
  output logic [1:0]       rresp,                    // read answer
  output logic             rvalid,                   // read data valid
  input  wire logic        rready,                   // read data taken
  input  wire logic        loop1_frame_tick,         // 8 kHz boundary, first loop
  input  wire logic        loop1_mframe_tick,        // 2 kHz boundary, first loop
  input  wire logic        loop2_frame_tick,         // 8 kHz boundary, second loop
  input  wire logic        loop2_mframe_tick,        // 2 kHz boundary, second loop
  input  wire logic        ext_frame_tick,           // 8 kHz boundary, sync input
  input  wire logic        ext_mframe_tick,          // 2 kHz boundary, sync input
  input  wire logic        o2_tick,                  // second output period pulse
  input  wire logic        o2_enabled,               // second output running
  output logic             frame_sync_out,           // 8 kHz frame sync
  output logic             multiframe_sync_out,      // 2 kHz multiframe sync
  output logic             sync_source_second_loop,  // loop feeding outputs one and two
  output logic             sync_outputs_independent, // sync outputs follow sync input
  output logic             fine_sampling_rate_select,// finer sync sampling
  output logic [1:0]       sample_phase_input_one,   // sampling phase, input one
  output logic [1:0]       sample_phase_input_two,   // sampling phase, input two
  output logic [1:0]       sample_phase_input_three  // sampling phase, input three
);
  sync_pulse_pkg::top_state_s s_reg;
  sync_pulse_pkg::top_state_s s_next;

  logic fr_start;
  logic mf_start;
  logic fr_pulsed_ok;
  logic mf_pulsed_ok;

  sync_wave_if fr_w ();
  sync_wave_if mf_w ();

  // {hit, index}; a hit needs word alignment and an address inside the map
  function automatic logic [8:0] decode(input logic [11:0] a);
    decode = {(a[1:0] == 2'h0) && (a[11:10] == 2'h0), a[9:2]};
  endfunction : decode

  function automatic logic [1:0] phase_field(input logic [7:0] r, input int lsb);
    phase_field = r[lsb+:2];
  endfunction : phase_field

  sync_start_select u_fr_sel (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .sel_loop2   (s_reg.pulse_cfg[`SRC_LOOP2_BIT]),
    .independent (s_reg.phase_cfg[`INDEP_BIT]),
    .loop1_tick  (loop1_frame_tick),
    .loop2_tick  (loop2_frame_tick),
    .ext_tick    (ext_frame_tick),
    .start       (fr_start)
  );

  sync_start_select u_mf_sel (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .sel_loop2   (s_reg.pulse_cfg[`SRC_LOOP2_BIT]),
    .independent (s_reg.phase_cfg[`INDEP_BIT]),
    .loop1_tick  (loop1_mframe_tick),
    .loop2_tick  (loop2_mframe_tick),
    .ext_tick    (ext_mframe_tick),
    .start       (mf_start)
  );

  // pulsed mode only while the second output runs
  assign fr_pulsed_ok = s_reg.pulse_cfg[`FR_PULSED_BIT] & o2_enabled;
  assign mf_pulsed_ok = s_reg.pulse_cfg[`MF_PULSED_BIT] & o2_enabled;

  assign fr_w.start      = fr_start;
  assign fr_w.o2_tick    = o2_tick;
  assign fr_w.pulsed_req = fr_pulsed_ok;
  assign fr_w.flip_req   = s_reg.pulse_cfg[`FR_FLIP_BIT];
  assign mf_w.start      = mf_start;
  assign mf_w.o2_tick    = o2_tick;
  assign mf_w.pulsed_req = mf_pulsed_ok;
  assign mf_w.flip_req   = s_reg.pulse_cfg[`MF_FLIP_BIT];

  sync_wave_gen u_fr_gen (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .w       (fr_w)
  );

  sync_wave_gen u_mf_gen (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .w       (mf_w)
  );

  always_comb begin
    logic [8:0] wdec;
    logic [8:0] rdec;
    wdec = decode(s_reg.awaddr);
    rdec = decode(araddr);
    s_next = s_reg;

    // write address and data, taken in either order
    if (awvalid && s_reg.awready) begin
      s_next.awaddr  = awaddr;
      s_next.aw_full = 1'b1;
    end
    if (wvalid && s_reg.wready) begin
      s_next.wdata  = wdata;
      s_next.wstrb  = wstrb;
      s_next.w_full = 1'b1;
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid) begin
      s_next.aw_full = 1'b0;
      s_next.w_full  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = `RESP_OKAY;
      if (wdec[8] && wdec[7:0] == `PULSE_CFG_IDX) begin
        if (s_reg.wstrb[0]) begin
          s_next.pulse_cfg = s_reg.wdata[7:0] & `PULSE_CFG_WMASK;
        end
      end else if (wdec[8] && wdec[7:0] == `PHASE_CFG_IDX) begin
        if (s_reg.wstrb[0]) begin
          s_next.phase_cfg = s_reg.wdata[7:0];
        end
      end else if (wdec[8] && wdec[7:0] == `STATUS_IDX) begin
        // writing a one clears the sticky flag; a new event wins
        if (s_reg.wstrb[0] && s_reg.wdata[5]) begin
          s_next.no_o2_seen = 1'b0;
        end
      end else begin
        s_next.bresp = `RESP_SLVERR;
      end
    end
    s_next.awready = !s_next.aw_full && !s_next.bvalid;
    s_next.wready  = !s_next.w_full && !s_next.bvalid;

    // read channel
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end
    if (arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = `RESP_OKAY;
      s_next.rdata  = '0;
      if (rdec[8] && rdec[7:0] == `PULSE_CFG_IDX) begin
        s_next.rdata[7:0] = s_reg.pulse_cfg;
      end else if (rdec[8] && rdec[7:0] == `PHASE_CFG_IDX) begin
        s_next.rdata[7:0] = s_reg.phase_cfg;
      end else if (rdec[8] && rdec[7:0] == `STATUS_IDX) begin
        s_next.rdata[5:0] = {s_reg.no_o2_seen, o2_enabled,
                             mf_w.pulsed_now, fr_w.pulsed_now,
                             s_reg.mfsync, s_reg.fsync};
      end else begin
        s_next.rresp = `RESP_SLVERR;
      end
    end
    s_next.arready = !s_next.rvalid;

    // pulsed asked for while the second output is off
    if ((s_reg.pulse_cfg[`FR_PULSED_BIT] || s_reg.pulse_cfg[`MF_PULSED_BIT]) && !o2_enabled) begin
      s_next.no_o2_seen = 1'b1;
    end

    s_next.fsync  = fr_w.level;
    s_next.mfsync = mf_w.level;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg           <= '0;
      s_reg.pulse_cfg <= `PULSE_CFG_RST;
      s_reg.phase_cfg <= `PHASE_CFG_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign awready                   = s_reg.awready;
  assign wready                    = s_reg.wready;
  assign bvalid                    = s_reg.bvalid;
  assign bresp                     = s_reg.bresp;
  assign arready                   = s_reg.arready;
  assign rvalid                    = s_reg.rvalid;
  assign rdata                     = s_reg.rdata;
  assign rresp                     = s_reg.rresp;
  assign frame_sync_out            = s_reg.fsync;
  assign multiframe_sync_out       = s_reg.mfsync;
  assign sync_source_second_loop   = s_reg.pulse_cfg[`SRC_LOOP2_BIT];
  assign sync_outputs_independent  = s_reg.phase_cfg[`INDEP_BIT];
  assign fine_sampling_rate_select = s_reg.phase_cfg[`FINE_RATE_BIT];
  assign sample_phase_input_one    = phase_field(s_reg.phase_cfg, `PH_IN1_LSB);
  assign sample_phase_input_two    = phase_field(s_reg.phase_cfg, `PH_IN2_LSB);
  assign sample_phase_input_three  = phase_field(s_reg.phase_cfg, `PH_IN3_LSB);
endmodule : sync_pulse_output_config
`default_nettype wire

// ===== logic/sync_pulse_defs.svh
// Purpose: offsets, field positions and reset values of the sync output block
// Assumes: register indices are word indices; byte address is four times the index
// Notes:   definitions only
`ifndef SYNC_PULSE_DEFS_SVH
`define SYNC_PULSE_DEFS_SVH

// register indices
`define PULSE_CFG_IDX    8'h7a
`define PHASE_CFG_IDX    8'h7b
`define STATUS_IDX       8'h40

// reset values
`define PULSE_CFG_RST    8'h00
`define PHASE_CFG_RST    8'h00

// pulse config fields
`define MF_PULSED_BIT    0
`define MF_FLIP_BIT      1
`define FR_PULSED_BIT    2
`define FR_FLIP_BIT      3
`define SRC_LOOP2_BIT    7
`define PULSE_CFG_WMASK  8'h8f

// phase config fields
`define PH_IN1_LSB       0
`define PH_IN2_LSB       2
`define PH_IN3_LSB       4
`define FINE_RATE_BIT    6
`define INDEP_BIT        7

// bus answers
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

// period measuring counter width; 2 kHz at 125 MHz is 62500 cycles
`define PERIOD_CNT_W     16

`endif

// ===== logic/sync_pulse_pkg.sv
// Purpose: types shared by the sync output block
// Assumes: constants come from sync_pulse_defs.svh
// Notes:   state structs, one per module
`default_nettype none
`include "sync_pulse_defs.svh"
package sync_pulse_pkg;

  typedef enum logic [1:0] {
    PH_ON_TARGET  = 2'h0,
    PH_EARLY_HALF = 2'h1,
    PH_LATE_ONE   = 2'h2,
    PH_LATE_HALF  = 2'h3
  } sample_phase_e;

  // gray order: idle -> high -> low -> high ...
  typedef enum logic [1:0] {
    WAVE_IDLE = 2'h0,
    WAVE_HIGH = 2'h1,
    WAVE_LOW  = 2'h3
  } wave_state_e;

  typedef struct packed {
    wave_state_e                 st;
    logic [`PERIOD_CNT_W-1:0]    cnt;
    logic [`PERIOD_CNT_W-1:0]    period_len;
    logic                        pulsed_act;
    logic                        flip_act;
    logic                        level;
    logic                        o2_d;
  } gen_state_s;

  typedef struct packed {
    logic start;
  } sel_state_s;

  typedef struct packed {
    logic [11:0] awaddr;
    logic        aw_full;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        w_full;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  pulse_cfg;
    logic [7:0]  phase_cfg;
    logic        fsync;
    logic        mfsync;
    logic        no_o2_seen;
  } top_state_s;

endpackage : sync_pulse_pkg
`default_nettype wire

// ===== logic/sync_wave_if.sv
// Purpose: control and result of one sync waveform generator
// Assumes: single clock domain
// Notes:   ctl side is the register block, gen side the generator
`default_nettype none
interface sync_wave_if;
  logic start;       // period boundary pulse
  logic o2_tick;     // one pulse per second clock output period
  logic pulsed_req;  // pulsed waveform requested and allowed
  logic flip_req;    // polarity inversion requested
  logic level;       // waveform level, inversion applied
  logic pulsed_now;  // pulsed mode in force this period

  modport gen (input start, input o2_tick, input pulsed_req, input flip_req,
               output level, output pulsed_now);
  modport ctl (output start, output o2_tick, output pulsed_req, output flip_req,
               input level, input pulsed_now);
endinterface : sync_wave_if
`default_nettype wire

// ===== logic/sync_start_select.sv
// Purpose: picks the period boundary of one sync output
// Assumes: ticks are one-cycle pulses in the ref_clk domain
// Notes:   registered, one cycle after the chosen tick
`default_nettype none
module sync_start_select (
  input  wire logic ref_clk,      // system clock
  input  wire logic sys_rst,      // async reset, high
  input  wire logic sel_loop2,    // take the second loop
  input  wire logic independent,  // follow the sync input
  input  wire logic loop1_tick,   // boundary from first loop
  input  wire logic loop2_tick,   // boundary from second loop
  input  wire logic ext_tick,     // boundary from sync input
  output logic      start         // chosen boundary pulse
);
  sync_pulse_pkg::sel_state_s s_reg;
  sync_pulse_pkg::sel_state_s s_next;

  always_comb begin
    s_next = s_reg;
    if (independent) begin
      s_next.start = ext_tick;
    end else begin
      s_next.start = sel_loop2 ? loop2_tick : loop1_tick;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign start = s_reg.start;
endmodule : sync_start_select
`default_nettype wire

// ===== logic/sync_wave_gen.sv
// Purpose: square or pulsed sync waveform with optional inversion
// Assumes: start pulses one period apart; o2_tick once per second output period
// Notes:   mode and polarity are taken only at a period boundary
`default_nettype none
`include "sync_pulse_defs.svh"
module sync_wave_gen (
  input  wire logic ref_clk,  // system clock
  input  wire logic sys_rst,  // async reset, high
  sync_wave_if.gen  w         // control and result
);
  sync_pulse_pkg::gen_state_s s_reg;
  sync_pulse_pkg::gen_state_s s_next;

  function automatic logic [`PERIOD_CNT_W-1:0] inc_sat(input logic [`PERIOD_CNT_W-1:0] v);
    inc_sat = (&v) ? v : v + `PERIOD_CNT_W'(1);
  endfunction : inc_sat

  always_comb begin
    s_next = s_reg;
    s_next.cnt = inc_sat(s_reg.cnt);
    // delayed to line up with the registered boundary
    s_next.o2_d = w.o2_tick;
    if (w.start) begin
      s_next.period_len = s_reg.cnt;
      s_next.cnt = `PERIOD_CNT_W'(1);
      s_next.pulsed_act = w.pulsed_req;
      s_next.flip_act = w.flip_req;
      s_next.st = sync_pulse_pkg::WAVE_HIGH;
    end else begin
      case (s_reg.st)
        sync_pulse_pkg::WAVE_IDLE: begin
          s_next.cnt = '0;
        end
        sync_pulse_pkg::WAVE_HIGH: begin
          if (s_reg.pulsed_act) begin
            if (s_reg.o2_d) begin
              s_next.st = sync_pulse_pkg::WAVE_LOW;
            end
          end else if (s_reg.period_len != '0 &&
                       s_reg.cnt >= (s_reg.period_len >> 1)) begin
            s_next.st = sync_pulse_pkg::WAVE_LOW;
          end
        end
        sync_pulse_pkg::WAVE_LOW: begin
          s_next.st = sync_pulse_pkg::WAVE_LOW;
        end
        default: begin
          s_next.st = sync_pulse_pkg::WAVE_IDLE;
        end
      endcase
    end
    s_next.level = (s_next.st == sync_pulse_pkg::WAVE_HIGH) ^ s_next.flip_act;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign w.level = s_reg.level;
  assign w.pulsed_now = s_reg.pulsed_act;
endmodule : sync_wave_gen
`default_nettype wire

// ===== test/sync_pulse_output_config_asserts.sv
// Purpose: bus answer and sync output checks for the sync output block
// Assumes: single ref_clk domain, sys_rst async active high
// Notes:   bound to the top module, sees its ports only
`default_nettype none
module sync_pulse_output_config_asserts (
  input wire logic        ref_clk,                   // system clock
  input wire logic        sys_rst,                   // async reset, high
  input wire logic        awvalid,                   // write address valid
  input wire logic        awready,                   // write address ready
  input wire logic        wvalid,                    // write data valid
  input wire logic        wready,                    // write data ready
  input wire logic [1:0]  bresp,                     // write answer
  input wire logic        bvalid,                    // write answer valid
  input wire logic        bready,                    // write answer taken
  input wire logic        arvalid,                   // read address valid
  input wire logic        arready,                   // read address ready
  input wire logic [31:0] rdata,                     // read data
  input wire logic [1:0]  rresp,                     // read answer
  input wire logic        rvalid,                    // read data valid
  input wire logic        rready,                    // read data taken
  input wire logic        loop1_frame_tick,          // boundary, first loop
  input wire logic        loop1_mframe_tick,         // boundary, first loop
  input wire logic        loop2_frame_tick,          // boundary, second loop
  input wire logic        loop2_mframe_tick,         // boundary, second loop
  input wire logic        ext_frame_tick,            // boundary, sync input
  input wire logic        ext_mframe_tick,           // boundary, sync input
  input wire logic        frame_sync_out,            // frame sync
  input wire logic        multiframe_sync_out,       // multiframe sync
  input wire logic        sync_source_second_loop,   // loop select
  input wire logic        sync_outputs_independent,  // independent mode
  input wire logic        fine_sampling_rate_select, // finer sampling
  input wire logic [1:0]  sample_phase_input_one,    // phase code one
  input wire logic [1:0]  sample_phase_input_two,    // phase code two
  input wire logic [1:0]  sample_phase_input_three   // phase code three
);
  timeunit 1ns;
  timeprecision 1ps;

  logic seen_tick_reg;
  logic any_tick;

  assign any_tick = loop1_frame_tick | loop1_mframe_tick | loop2_frame_tick |
                    loop2_mframe_tick | ext_frame_tick | ext_mframe_tick;

  // remembers whether any boundary has arrived since reset
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      seen_tick_reg <= 1'b0;
    end else begin
      seen_tick_reg <= seen_tick_reg | any_tick;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence both_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence answer_soon;
    ##[1:2] bvalid;
  endsequence

  src_loop_hold_a: assert property ($changed(sync_source_second_loop) |-> $rose(bvalid))
    else $error("loop select moved without a write");
  phase_cfg_hold_a: assert property ($changed({sync_outputs_independent, fine_sampling_rate_select,
      sample_phase_input_three, sample_phase_input_two, sample_phase_input_one}) |-> $rose(bvalid))
    else $error("phase outputs moved without a write");
  write_answer_a: assert property (both_taken |-> answer_soon)
    else $error("write answer missing");
  write_refuse_a: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while answer pending");
  write_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped early");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped early");
  idle_output_a: assert property (!seen_tick_reg |-> !frame_sync_out && !multiframe_sync_out)
    else $error("sync output active before first boundary");
endmodule : sync_pulse_output_config_asserts

bind sync_pulse_output_config sync_pulse_output_config_asserts u_chk (
  .ref_clk, .sys_rst, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .loop1_frame_tick, .loop1_mframe_tick,
  .loop2_frame_tick, .loop2_mframe_tick, .ext_frame_tick, .ext_mframe_tick, .frame_sync_out,
  .multiframe_sync_out, .sync_source_second_loop, .sync_outputs_independent,
  .fine_sampling_rate_select, .sample_phase_input_one, .sample_phase_input_two, .sample_phase_input_three
);
`default_nettype wire

// ===== test/sync_pulse_output_config_tb_top.sv
// Purpose: register and waveform tests of the sync output block
// Assumes: AXI4-Lite access, boundaries made by a free counter
// Notes:   counts over one common period of all sources
`default_nettype none
`include "sync_pulse_defs.svh"
module sync_pulse_output_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [11:0] PULSE_A = {2'h0, `PULSE_CFG_IDX, 2'h0};
  localparam logic [11:0] PHASE_A = {2'h0, `PHASE_CFG_IDX, 2'h0};
  localparam int          WIN     = 768;
  localparam int          O2P     = 8;

  logic ref_clk = 1'b0, sys_rst = 1'b1, o2_run = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, ph1, ph2, ph3;
  logic l1f = 1'b0, l1m = 1'b0, l2f = 1'b0, l2m = 1'b0, exf = 1'b0, exm = 1'b0, o2t = 1'b0, o2e = 1'b0;
  logic fr_out, mf_out, src2, indep, fine;
  int   k = 0, n_fail = 0, n_compared = 0;

  sync_pulse_output_config i_dut (
    .ref_clk, .sys_rst, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .loop1_frame_tick(l1f), .loop1_mframe_tick(l1m),
    .loop2_frame_tick(l2f), .loop2_mframe_tick(l2m), .ext_frame_tick(exf), .ext_mframe_tick(exm),
    .o2_tick(o2t), .o2_enabled(o2e), .frame_sync_out(fr_out), .multiframe_sync_out(mf_out),
    .sync_source_second_loop(src2), .sync_outputs_independent(indep), .fine_sampling_rate_select(fine),
    .sample_phase_input_one(ph1), .sample_phase_input_two(ph2), .sample_phase_input_three(ph3)
  );

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  // boundaries: loop1 128/32, loop2 192/48, sync input 256/64 cycles
  always @(posedge ref_clk) begin
    k   <= sys_rst ? 0 : k + 1;
    l1m <= !sys_rst && (k % 128 == 0);
    l1f <= !sys_rst && (k % 32 == 0);
    l2m <= !sys_rst && (k % 192 == 0);
    l2f <= !sys_rst && (k % 48 == 0);
    exm <= !sys_rst && (k % 256 == 0);
    exf <= !sys_rst && (k % 64 == 0);
    o2t <= !sys_rst && o2_run && (k % O2P == 0);
    o2e <= o2_run;
  end

  task automatic check_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : check_val

  task automatic check_range(input string nm, input int lo, input int hi, input int got);
    n_compared++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : check_range

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  task automatic bus_wait(inout int n);
    n++;
    if (n > 200) begin
      n_fail++;
      finish_test();
    end
  endtask : bus_wait

  task automatic write_reg(input logic [11:0] a, input logic [31:0] d, input logic [1:0] exp_r);
    logic aw_t, w_t, b_t, b_seen;
    logic [1:0] r;
    int n;
    n = 0;
    b_t = 1'b0;
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'h1;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!b_t) begin
      @(negedge ref_clk);
      aw_t   = awvalid && awready;
      w_t    = wvalid && wready;
      b_t    = bvalid && bready;
      b_seen = bvalid;
      r      = bresp;
      @(posedge ref_clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) bready <= 1'b0;
      else if (b_seen) bready <= 1'b1;
      bus_wait(n);
    end
    check_val("bresp", {30'h0, exp_r}, {30'h0, r});
  endtask : write_reg

  task automatic read_chk(input logic [11:0] a, input logic [31:0] exp_d, input logic [1:0] exp_r);
    logic ar_t, r_t, r_seen;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    r_t = 1'b0;
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    while (!r_t) begin
      @(negedge ref_clk);
      ar_t   = arvalid && arready;
      r_t    = rvalid && rready;
      r_seen = rvalid;
      d      = rdata;
      r      = rresp;
      @(posedge ref_clk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) rready <= 1'b0;
      else if (r_seen) rready <= 1'b1;
      bus_wait(n);
    end
    check_val("rdata", exp_d, d);
    check_val("rresp", {30'h0, exp_r}, {30'h0, r});
  endtask : read_chk

  // counts rising edges and high cycles of both outputs over one window
  task automatic measure(output int em, output int hm, output int ef, output int hf);
    logic pm, pf;
    em = 0;
    hm = 0;
    ef = 0;
    hf = 0;
    repeat (530) @(posedge ref_clk);
    @(negedge ref_clk);
    pm = mf_out;
    pf = fr_out;
    repeat (WIN) begin
      @(negedge ref_clk);
      if (mf_out === 1'b1 && pm !== 1'b1) em++;
      if (fr_out === 1'b1 && pf !== 1'b1) ef++;
      if (mf_out === 1'b1) hm++;
      if (fr_out === 1'b1) hf++;
      pm = mf_out;
      pf = fr_out;
    end
  endtask : measure

  // cfg, phase, o2 running, multiframe period, mode (0 square, 1 pulsed, 2 pulsed flipped)
  logic [7:0] t_cfg [6] = '{8'h00, 8'h05, 8'h0f, 8'h05, 8'h85, 8'h85};
  logic [7:0] t_ph  [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80};
  logic       t_o2  [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  int         t_per [6] = '{128, 128, 128, 128, 192, 256};
  int         t_mode[6] = '{0, 1, 2, 0, 1, 1};

  initial begin
    int em, hm, ef, hf, e, f;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    read_chk(PULSE_A, 32'h0, `RESP_OKAY);
    read_chk(PHASE_A, 32'h0, `RESP_OKAY);
    write_reg(PULSE_A, 32'hff, `RESP_OKAY);
    read_chk(PULSE_A, 32'h8f, `RESP_OKAY);
    check_val("loop select", 32'h1, {31'h0, src2});
    for (int i = 0; i < 4; i++) begin
      write_reg(PHASE_A, 32'h80 | (i * 32'h15), `RESP_OKAY);
      check_val("phase codes", {26'h0, 2'(i), 2'(i), 2'(i)}, {26'h0, ph3, ph2, ph1});
      check_val("independent", 32'h1, {31'h0, indep});
    end
    write_reg(PHASE_A, 32'h40, `RESP_OKAY);
    check_val("fine and indep", 32'h2, {30'h0, fine, indep});
    read_chk(12'h004, 32'h0, `RESP_SLVERR);
    write_reg(12'h008, 32'hff, `RESP_SLVERR);
    read_chk(PHASE_A, 32'h40, `RESP_OKAY);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      write_reg(PHASE_A, {24'h0, t_ph[i]}, `RESP_OKAY);
      write_reg(PULSE_A, {24'h0, t_cfg[i]}, `RESP_OKAY);
      o2_run <= t_o2[i];
      measure(em, hm, ef, hf);
      e = WIN / t_per[i];
      f = 4 * e;
      check_range("mframe edges", e, e, em);
      check_range("frame edges", f, f, ef);
      if (t_mode[i] == 0) begin
        check_range("mframe high", WIN / 2 - 2 * e, WIN / 2 + 2 * e, hm);
        check_range("frame high", WIN / 2 - 2 * f, WIN / 2 + 2 * f, hf);
      end else if (t_mode[i] == 1) begin
        check_range("mframe high", e * O2P, e * O2P, hm);
        check_range("frame high", f * O2P, f * O2P, hf);
      end else begin
        check_range("mframe high", WIN - e * O2P, WIN - e * O2P, hm);
        check_range("frame high", WIN - f * O2P, WIN - f * O2P, hf);
      end
      $display("test waveform %0d done", i);
    end
    finish_test();
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    n_fail++;
    finish_test();
  end
endmodule : sync_pulse_output_config_tb_top
`default_nettype wire
